// *** design/bdr_pkg.sv ***
// Package: constants, pin groups and state type of the bus data register
package bdr_pkg;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int DATA_WIDTH = 8;
  localparam int OE_COUNT   = 3;
  localparam int ADDR_WIDTH = 8;
  localparam int BUS_WIDTH  = 32;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [ADDR_WIDTH-1:0] REG_CTRL    = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] REG_STATUS  = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] REG_BUSVIEW = 8'h08;

  // Control fields
  localparam int CTRL_INVERT_BIT = 0;
  localparam int CTRL_HOLD_BIT   = 1;
  localparam int CTRL_WIPE_BIT   = 2;
  localparam int CTRL_WIDTH      = 3;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 3'h0;

  // Status fields
  localparam int STAT_BITS_LSB   = 0;
  localparam int STAT_LOADED_BIT = 8;
  localparam int STAT_DRIVE_BIT  = 9;

  // Busview fields
  localparam int VIEW_OE_BIT = 8;

  // Reset values
  localparam logic [DATA_WIDTH-1:0] BITS_RESET = 8'h00;
  localparam logic [BUS_WIDTH-1:0]  WORD_ZERO  = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [OE_COUNT-1:0]   outEnN;
    logic                  wipeN;
    logic                  clkEnN;
    logic [DATA_WIDTH-1:0] data;
  } bdr_pins_type;

  typedef struct packed {
    logic [DATA_WIDTH-1:0] value;
    logic [DATA_WIDTH-1:0] oe;
  } bdr_bus_type;

  // ----------------------------------------------------------------------
  // Contents state
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_EMPTY  = 2'h0,
    ST_LOADED = 2'h1
  } bdr_state_type;

endpackage

// *** design/bdr_store.sv ***
// Eight storage flip-flops with clear and active-low clock enable
`timescale 1ns/10ps
`default_nettype none

module bdr_store (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Controls
  input  wire logic                          wipeN,
  input  wire logic                          clkEnN,
  input  wire logic                          holdSw,
  input  wire logic [bdr_pkg::DATA_WIDTH-1:0] dataIn,
  // State
  output logic      [bdr_pkg::DATA_WIDTH-1:0] bits_q,
  output logic      [bdr_pkg::DATA_WIDTH-1:0] bits_d,
  output logic                               loadNow,
  output logic                               clearNow
);
  import bdr_pkg::*;

  // ----------------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------------
  always_comb begin
    clearNow = ~wipeN;
    loadNow  = wipeN & ~clkEnN & ~holdSw;
    bits_d   = bits_q;
    if (clearNow) begin
      bits_d = BITS_RESET;
    end else if (loadNow) begin
      bits_d = dataIn;
    end
  end

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Eight bits, rising edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bits_q <= BITS_RESET;
    end else begin
      bits_q <= bits_d;
    end
  end

endmodule

`default_nettype wire

// *** design/bdr_reg.sv ***
// Top of the bus data register: storage, output drive and register port
`timescale 1ns/10ps
`default_nettype none

module bdr_reg (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst,
  // Device pins
  input  wire bdr_pkg::bdr_pins_type         pins,
  output logic      [bdr_pkg::DATA_WIDTH-1:0] busValue,
  output logic      [bdr_pkg::DATA_WIDTH-1:0] busOe,
  // Register port
  input  wire logic [bdr_pkg::ADDR_WIDTH-1:0] regAddr,
  input  wire logic [bdr_pkg::BUS_WIDTH-1:0]  regWrData,
  input  wire logic                          regWrStb,
  input  wire logic                          regRdStb,
  output logic      [bdr_pkg::BUS_WIDTH-1:0]  regRdData
);
  import bdr_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic allLow(input logic [OE_COUNT-1:0] enN);
    allLow = ~|enN;
  endfunction

  function automatic logic [DATA_WIDTH-1:0] shapeOut(
    input logic [DATA_WIDTH-1:0] bits,
    input logic                  invert,
    input logic                  loaded
  );
    shapeOut = (invert & loaded) ? ~bits : bits;
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [DATA_WIDTH-1:0] bits_q;
  logic [DATA_WIDTH-1:0] bits_d;
  logic                  loadNow;
  logic                  clearNow;
  logic                  wipeEff;
  bdr_state_type         state_q;
  bdr_state_type         state_d;
  logic                  drive_d;
  logic                  drive_q;
  logic [DATA_WIDTH-1:0] shaped_d;
  bdr_bus_type           bus_q;
  logic [BUS_WIDTH-1:0]  rdWord;
  logic [BUS_WIDTH-1:0]  rdData_q;

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  assign wipeEff = pins.wipeN & ~ctrl_q[CTRL_WIPE_BIT];

  bdr_store u_store (
    .core_clk (core_clk),
    .rst      (rst),
    .wipeN    (wipeEff),
    .clkEnN   (pins.clkEnN),
    .holdSw   (ctrl_q[CTRL_HOLD_BIT]),
    .dataIn   (pins.data),
    .bits_q   (bits_q),
    .bits_d   (bits_d),
    .loadNow  (loadNow),
    .clearNow (clearNow)
  );

  // ----------------------------------------------------------------------
  // Contents state
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_EMPTY: begin
        if (!clearNow && loadNow) begin
          state_d = ST_LOADED;
        end
      end
      ST_LOADED: begin
        if (clearNow) begin
          state_d = ST_EMPTY;
        end
      end
      default: begin
        state_d = ST_EMPTY;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_EMPTY;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Output drive
  // ----------------------------------------------------------------------
  // All three enables low to drive
  assign drive_d = allLow(pins.outEnN);

  assign shaped_d = shapeOut(bits_d, ctrl_q[CTRL_INVERT_BIT],
                             state_d == ST_LOADED);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive_d;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bus_q <= '0;
    end else begin
      bus_q.value <= shaped_d;
      bus_q.oe    <= {DATA_WIDTH{drive_d}};
    end
  end

  assign busValue = bus_q.value;
  assign busOe    = bus_q.oe;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (regWrStb && regAddr == REG_CTRL) begin
      ctrl_q <= regWrData[CTRL_WIDTH-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_comb begin
    rdWord = WORD_ZERO;
    case (regAddr)
      REG_CTRL: begin
        rdWord[CTRL_WIDTH-1:0] = ctrl_q;
      end
      REG_STATUS: begin
        rdWord[STAT_BITS_LSB +: DATA_WIDTH] = bits_q;
        rdWord[STAT_LOADED_BIT] = (state_q == ST_LOADED);
        rdWord[STAT_DRIVE_BIT]  = drive_q;
      end
      REG_BUSVIEW: begin
        rdWord[DATA_WIDTH-1:0] = bus_q.value;
        rdWord[VIEW_OE_BIT]    = bus_q.oe[0];
      end
      default: begin
        rdWord = WORD_ZERO;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_q <= WORD_ZERO;
    end else if (regRdStb) begin
      rdData_q <= rdWord;
    end else begin
      rdData_q <= WORD_ZERO;
    end
  end

  assign regRdData = rdData_q;

endmodule

`default_nettype wire

// *** verification/bdr_reg_asserts.sv ***
// Checker: pin relations of the bus data register
`timescale 1ns/10ps
`default_nettype none
module bdr_reg_asserts (
  // Clock and reset
  input wire logic                          core_clk,
  input wire logic                          rst,
  // Watched ports
  input wire bdr_pkg::bdr_pins_type         pins,
  input wire logic [bdr_pkg::DATA_WIDTH-1:0] busValue,
  input wire logic [bdr_pkg::DATA_WIDTH-1:0] busOe,
  input wire logic [bdr_pkg::ADDR_WIDTH-1:0] regAddr,
  input wire logic [bdr_pkg::BUS_WIDTH-1:0]  regWrData,
  input wire logic                          regWrStb,
  input wire logic                          regRdStb,
  input wire logic [bdr_pkg::BUS_WIDTH-1:0]  regRdData
);
  import bdr_pkg::*;
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic                  wrPrev_q;
  logic                  load;
  logic                  quiet;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) ctrl_q <= CTRL_RESET;
    else if (regWrStb && regAddr == REG_CTRL)
      ctrl_q <= regWrData[CTRL_WIDTH-1:0];
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) wrPrev_q <= 1'b0;
    else wrPrev_q <= regWrStb;
  end
  assign load = pins.wipeN & ~pins.clkEnN & ~ctrl_q[CTRL_HOLD_BIT]
              & ~ctrl_q[CTRL_WIPE_BIT];
  assign quiet = pins.wipeN & pins.clkEnN & ~regWrStb & ~wrPrev_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  drive_all_a: assert property (
    pins.outEnN == 3'h0 |=> busOe == 8'hFF) else $error("bus not driven");
  float_any_a: assert property (
    |pins.outEnN |=> busOe == 8'h00) else $error("bus not floated");
  oe_keep_a: assert property (
    $changed(pins.outEnN) && quiet |=> $stable(busValue))
    else $error("enable moved data");
  clear_low_a: assert property (
    !pins.wipeN |=> busValue == 8'h00) else $error("clear not zero");
  clear_stay_a: assert property (
    !pins.wipeN ##1 !pins.wipeN |-> busValue == 8'h00)
    else $error("load during clear");
  load_true_a: assert property (
    load && !ctrl_q[0] |=> busValue == $past(pins.data))
    else $error("load wrong");
  load_inv_a: assert property (
    load && ctrl_q[0] |=> busValue == ~$past(pins.data))
    else $error("inverted load wrong");
  hold_still_a: assert property (
    quiet |=> $stable(busValue)) else $error("hold changed data");
  cover property (load ##1 pins.outEnN == 3'h0);
  cover property (!pins.wipeN && !pins.clkEnN);
  cover property (load && ctrl_q[0]);
endmodule
bind bdr_reg bdr_reg_asserts u_chk (.core_clk(core_clk), .rst(rst),
  .pins(pins), .busValue(busValue), .busOe(busOe), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
  .regRdData(regRdData));
`default_nettype wire

// *** verification/bdr_bus_model.sv ***
// Partner: shared bus with another talker when released
`timescale 1ns/10ps
`default_nettype none
module bdr_bus_model (
  // Device side
  input  wire logic [bdr_pkg::DATA_WIDTH-1:0] busValue,
  input  wire logic [bdr_pkg::DATA_WIDTH-1:0] busOe,
  // Bus wire
  output logic      [bdr_pkg::DATA_WIDTH-1:0] busWire
);
  // other talker drives the inverse of released bits
  assign busWire = (busValue & busOe) | (~busValue & ~busOe);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// Testbench: random pin traffic checked through register reads
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bdr_pkg::*;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  bdr_pins_type          pins = '0;
  logic [DATA_WIDTH-1:0] busValue, busOe, busWire, bits = 8'h00;
  logic [ADDR_WIDTH-1:0] regAddr = 8'h00;
  logic [BUS_WIDTH-1:0]  regWrData = 32'h0, regRdData, seed = 32'h48F1;
  logic                  regWrStb = 1'b0, regRdStb = 1'b0, rdSeen = 1'b0;
  logic                  loaded = 1'b0, drive = 1'b0;
  logic [2:0]            ctrl = 3'h0;
  logic [31:0]           expQ[$];
  int                    mismatches = 0, checks = 0;
  always #10 core_clk = ~core_clk;
  bdr_reg DUT (.core_clk(core_clk), .rst(rst), .pins(pins),
    .busValue(busValue), .busOe(busOe), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData));
  bdr_bus_model u_bus (.busValue(busValue), .busOe(busOe),
    .busWire(busWire));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge core_clk);
    regWrStb <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    if (a == REG_CTRL) ctrl = d[2:0];
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    regRdStb <= 1'b1; regAddr <= a;
    expQ.push_back(e);
    @(posedge core_clk);
    regRdStb <= 1'b0;
  endtask
  task automatic step(logic [2:0] oe, logic w, logic e, logic [7:0] d);
    logic [7:0] sh;
    @(posedge core_clk);
    pins <= {oe, w, e, d};
    @(posedge core_clk);
    pins <= {oe, 1'b1, 1'b1, ~d};
    if (!(w & ~ctrl[2])) begin bits = 8'h00; loaded = 1'b0; end
    else if (!e && !ctrl[1]) begin bits = d; loaded = 1'b1; end
    drive = (oe == 3'h0);
    sh = (ctrl[0] & loaded) ? ~bits : bits;
    rd(REG_STATUS, {22'h0, drive, loaded, bits});
    rd(REG_BUSVIEW, {23'h0, drive, sh});
    check({24'h0, busWire}, {24'h0, drive ? sh : ~sh});
  endtask
  // Compare each read answer with the oldest note
  always @(posedge core_clk) begin
    if (rdSeen) check(regRdData, expQ.pop_front());
    rdSeen <= regRdStb;
  end
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd(8'h0C, 32'h0);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(REG_CTRL, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(REG_CTRL, 32'(c));
      rd(REG_CTRL, 32'(c));
      repeat (14) begin
        seed = xs(seed);
        step(seed[4] ? 3'h0 : seed[2:0], seed[5] | seed[6], seed[7],
          seed[15:8]);
      end
    end
    repeat (2) @(posedge core_clk);
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    print_verdict;
  end
endmodule
`default_nettype wire
